// >>> logic/pbbms_top.sv
// port b bus matching and byte swapping path of a two-way queue device
// Function
// [R1] long-word read presents bytes in selected swap order
// [R2] big-endian word reads: upper half first, upper lanes
// [R3] little-endian word reads: lower half first, lower lanes
// [R4] byte reads: top lane forward, bottom lane reversed
// [R5] byte writes reassembled by inverse swap
// [R6] word reads leave unused half holding old data
// [R7] byte reads leave unused lanes holding old data
// [R8] both size selects high reads the mailbox
// [R9] empty flag rises next cycle after loading
// [R10] partial sizes drop flag on last part only
// [R11] controller drives both size selects low for long
// [R12] long-word writes undo the selected swap
// [R13] word writes reassembled by inverse swap
// [R14] controller holds selects steady within a long word
//
// The implementer's own choices: strobed register access and the register offsets.
`include "pbbms_defines.svh"

module pbbms_top (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire pbbms_pkg::pbbms_reg_req_t reg_req,
  output logic      [31:0]              reg_rdata,
  output logic                          irq,
  input  wire logic [35:0]              a_to_b_data,
  input  wire logic                     a_to_b_valid,
  output logic                          a_to_b_ready,
  input  wire pbbms_pkg::pbbms_ctrl_t   port_b_ctrl,
  input  wire logic                     port_b_read,
  input  wire logic                     port_b_write,
  input  wire logic [35:0]              port_b_wdata,
  output logic      [35:0]              port_b_rdata,
  output logic                          port_b_empty_flag,
  output logic      [35:0]              b_to_a_data,
  output logic                          b_to_a_valid,
  input  wire logic                     b_to_a_ready
);
  import pbbms_pkg::*;

  pbbms_size_t         size;
  pbbms_swap_t         swap_code;
  logic                be;
  logic [35:0]         hold_word;
  logic                holding;
  logic                next_holding;
  logic [1:0]          rd_idx;
  logic [1:0]          wr_idx;
  logic [35:0]         swapped_rd;
  logic [35:0]         asm_word;
  logic [35:0]         next_asm;
  logic [35:0]         unswapped_wr;
  logic [35:0]         mail_ab;
  logic [35:0]         mail_ba;
  logic                rd_last;
  logic                wr_last;
  logic                q_read;
  logic                q_write;
  logic                mail_read;
  logic                mail_write;
  logic                load;
  logic                refused;
  logic [1:0]          rd_half;
  logic [1:0]          rd_lane;
  logic [1:0]          wr_half;
  logic [1:0]          wr_lane;
  logic [4:0]          events;
  logic [4:0]          ev_status;
  logic [4:0]          ev_enable;
  logic                clear_wr;
  logic                enable_wr;

  // decode port b control pins
  // read live on every access, so a change inside a long word
  // would mix lane maps; the controller keeps them steady
  assign size      = pbbms_size_t'({port_b_ctrl.bus_size_select_1,
                                    port_b_ctrl.bus_size_select_0});
  assign swap_code = pbbms_swap_t'({port_b_ctrl.swap_select_high,
                                    port_b_ctrl.swap_select_low});
  assign be        = port_b_ctrl.big_endian;

  // classify port b accesses
  // mailbox accesses bypass the queue path and its counters
  // a refused access only raises a status bit
  assign mail_read  = port_b_read && (size == PBBMS_SIZE_MAIL); // R8
  assign mail_write = port_b_write && (size == PBBMS_SIZE_MAIL);
  assign q_read     = port_b_read && (size != PBBMS_SIZE_MAIL) && holding;
  assign q_write    = port_b_write && (size != PBBMS_SIZE_MAIL) && b_to_a_ready;
  assign refused    = (port_b_read && (size != PBBMS_SIZE_MAIL) && !holding)
                    || (port_b_write && (size != PBBMS_SIZE_MAIL) && !b_to_a_ready);

  // long word closes on the part that matches the bus size
  // mailbox size never closes a long word
  always_comb begin
    case (size)
      PBBMS_SIZE_LONG: rd_last = 1'b1; // R11
      PBBMS_SIZE_WORD: rd_last = (rd_idx == `PBBMS_LAST_WORD);
      PBBMS_SIZE_BYTE: rd_last = (rd_idx == `PBBMS_LAST_BYTE);
      default:         rd_last = 1'b0;
    endcase
  end

  // same closing rule on the write side
  always_comb begin
    case (size)
      PBBMS_SIZE_LONG: wr_last = 1'b1;
      PBBMS_SIZE_WORD: wr_last = (wr_idx == `PBBMS_LAST_WORD);
      PBBMS_SIZE_BYTE: wr_last = (wr_idx == `PBBMS_LAST_BYTE);
      default:         wr_last = 1'b0;
    endcase
  end

  // a to b direction

  // queue output register loads only while empty
  // ready is registered, so a load lands only while nothing is held
  assign load = a_to_b_valid && a_to_b_ready;

  // the closing part frees the register, a load fills it
  always_comb begin
    next_holding = holding;
    if (q_read && rd_last) begin
      next_holding = 1'b0; // R10
    end
    if (load) begin
      next_holding = 1'b1;
    end
  end

  // held long word and its presence
  // the word changes only on a load, so every part of a long word
  // is taken from the same held word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_word <= `PBBMS_RST_LW;
      holding   <= 1'b0;
    end else begin
      holding <= next_holding;
      if (load) begin
        hold_word <= a_to_b_data;
      end
    end
  end

  // flag high one edge after the load into an empty path
  // one clock domain, so no skew allowance: the flag rises on the
  // edge right after the load
  // ready mirrors it and holds off a second word until the first drains
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_b_empty_flag <= 1'b0;
      a_to_b_ready      <= 1'b1;
    end else begin
      port_b_empty_flag <= next_holding; // R9 R10
      a_to_b_ready      <= !next_holding;
    end
  end

  // read part counter, restarts after the closing part
  // refused and mailbox reads leave the count alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_idx <= `PBBMS_IDX_FIRST;
    end else if (q_read) begin
      rd_idx <= rd_last ? `PBBMS_IDX_FIRST : rd_idx + `PBBMS_IDX_STEP; // R14
    end
  end

  // swap the held word for port b
  // every swap code is its own inverse, so one module serves both ways
  pbbms_swap u_rd_swap (
    .din  (hold_word),
    .code (swap_code),
    .dout (swapped_rd)
  );

  // half and lane picked by part number and endian
  // big endian starts on the upper half, little endian on the lower
  assign rd_half = {1'b0, be ^ rd_idx[0]};               // R2 R3
  assign rd_lane = be ? ~rd_idx : rd_idx;                // R4

  // port b output register; only the addressed lanes change
  // untouched lanes keep what the last queue or mailbox read left there
  // mailbox reads replace all lanes and leave the part counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_b_rdata <= `PBBMS_RST_LW;
    end else if (mail_read) begin
      port_b_rdata <= mail_ab; // R8
    end else if (q_read) begin
      case (size)
        PBBMS_SIZE_LONG: port_b_rdata <= swapped_rd; // R1
        PBBMS_SIZE_WORD: begin
          if (be) begin
            port_b_rdata[35:18] <= swapped_rd[rd_half*`PBBMS_HALF_BITS +: 18]; // R2 R6
          end else begin
            port_b_rdata[17:0] <= swapped_rd[rd_half*`PBBMS_HALF_BITS +: 18]; // R3 R6
          end
        end
        PBBMS_SIZE_BYTE: begin
          if (be) begin
            port_b_rdata[35:27] <= swapped_rd[rd_lane*`PBBMS_BYTE_BITS +: 9]; // R4 R7
          end else begin
            port_b_rdata[8:0] <= swapped_rd[rd_lane*`PBBMS_BYTE_BITS +: 9]; // R4 R7
          end
        end
        default: port_b_rdata <= port_b_rdata;
      endcase
    end
  end

  // b to a direction

  // write parts land where a read of the same part would come from
  // so a read and a write of one part use the same lanes
  assign wr_half = {1'b0, be ^ wr_idx[0]};
  assign wr_lane = be ? ~wr_idx : wr_idx;

  // assembly of the swapped long word from parts
  // lanes not yet written hold parts of the previous word
  always_comb begin
    next_asm = asm_word;
    case (size)
      PBBMS_SIZE_LONG: next_asm = port_b_wdata; // R12
      PBBMS_SIZE_WORD: begin
        if (be) begin
          next_asm[wr_half*`PBBMS_HALF_BITS +: 18] = port_b_wdata[35:18]; // R13
        end else begin
          next_asm[wr_half*`PBBMS_HALF_BITS +: 18] = port_b_wdata[17:0]; // R13
        end
      end
      PBBMS_SIZE_BYTE: begin
        if (be) begin
          next_asm[wr_lane*`PBBMS_BYTE_BITS +: 9] = port_b_wdata[35:27]; // R5
        end else begin
          next_asm[wr_lane*`PBBMS_BYTE_BITS +: 9] = port_b_wdata[8:0]; // R5
        end
      end
      default: next_asm = asm_word;
    endcase
  end

  // undo the swap on the assembled word
  // taken from next_asm so the closing part is already included
  pbbms_swap u_wr_swap (
    .din  (next_asm),
    .code (swap_code),
    .dout (unswapped_wr)
  );

  // partial assembly register and write part counter
  // a dropped write leaves both the word and the count unchanged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      asm_word <= `PBBMS_RST_LW;
      wr_idx   <= `PBBMS_IDX_FIRST;
    end else if (q_write) begin
      asm_word <= next_asm;
      wr_idx   <= wr_last ? `PBBMS_IDX_FIRST : wr_idx + `PBBMS_IDX_STEP;
    end
  end

  // deliver the rebuilt long word toward port a for one cycle
  // port a side must be ready on every part or that part is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_to_a_data  <= `PBBMS_RST_LW;
      b_to_a_valid <= 1'b0;
    end else begin
      b_to_a_valid <= q_write && wr_last;
      if (q_write && wr_last) begin
        b_to_a_data <= unswapped_wr; // R5 R12 R13
      end
    end
  end

  // mailboxes and registers

  // a to b mailbox written by software, b to a by port b
  // upper four bits of the software mailbox read back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mail_ab <= `PBBMS_RST_LW;
    end else if (reg_req.write && reg_req.addr == `PBBMS_OFF_MAIL_AB) begin
      mail_ab <= {4'h0, reg_req.wdata};
    end
  end

  // a mailbox-size port b write fills all four lanes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mail_ba <= `PBBMS_RST_LW;
    end else if (mail_write) begin
      mail_ba <= port_b_wdata;
    end
  end

  // events feeding the sticky status
  // each event is a one-cycle pulse; the status bit makes it sticky
  // a refused access counts once per offending strobe
  always_comb begin
    events = `PBBMS_RST_EV;
    events[`PBBMS_EV_LOADED]   = load;
    events[`PBBMS_EV_DRAINED]  = q_read && rd_last;
    events[`PBBMS_EV_ASSEMBLD] = q_write && wr_last;
    events[`PBBMS_EV_REFUSED]  = refused;
    events[`PBBMS_EV_MAIL_BA]  = mail_write;
  end

  // write-only clear and read-write enable share the status layout
  assign clear_wr  = reg_req.write && (reg_req.addr == `PBBMS_OFF_CLEAR);
  assign enable_wr = reg_req.write && (reg_req.addr == `PBBMS_OFF_ENABLE);

  // sticky status and level interrupt
  pbbms_irq u_irq (
    .clk       (clk),
    .rst       (rst),
    .events    (events),
    .clear_wr  (clear_wr),
    .enable_wr (enable_wr),
    .wdata     (reg_req.wdata[4:0]),
    .status    (ev_status),
    .enable    (ev_enable),
    .irq       (irq)
  );

  // read data one cycle after the read strobe; unmapped reads as zero
  // the write-only clear offset reads as zero too
  // zero outside the cycle after a read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `PBBMS_RST_REG;
    end else if (reg_req.read) begin
      case (reg_req.addr)
        `PBBMS_OFF_MAIL_AB: reg_rdata <= mail_ab[31:0];
        `PBBMS_OFF_MAIL_BA: reg_rdata <= mail_ba[31:0];
        `PBBMS_OFF_STATUS:  reg_rdata <= {27'h000_0000, ev_status};
        `PBBMS_OFF_ENABLE:  reg_rdata <= {27'h000_0000, ev_enable};
        // holding flag, then read part, then write part
        `PBBMS_OFF_STATE:   reg_rdata <= {27'h000_0000, holding, rd_idx, wr_idx};
        default:            reg_rdata <= `PBBMS_RST_REG;
      endcase
    end else begin
      reg_rdata <= `PBBMS_RST_REG;
    end
  end

endmodule

// >>> logic/pbbms_defines.svh
// constants for the port b bus matching and byte swap path
`ifndef PBBMS_DEFINES_SVH
`define PBBMS_DEFINES_SVH

// data widths
`define PBBMS_LW_BITS     36
`define PBBMS_HALF_BITS   18
`define PBBMS_BYTE_BITS   9
`define PBBMS_REG_BITS    32
`define PBBMS_ADDR_BITS   8

// register offsets (byte addresses)
`define PBBMS_OFF_MAIL_AB 8'h00
`define PBBMS_OFF_MAIL_BA 8'h04
`define PBBMS_OFF_STATUS  8'h08
`define PBBMS_OFF_CLEAR   8'h0C
`define PBBMS_OFF_ENABLE  8'h10
`define PBBMS_OFF_STATE   8'h14

// event bit positions in status, clear and enable
`define PBBMS_EV_LOADED   0
`define PBBMS_EV_DRAINED  1
`define PBBMS_EV_ASSEMBLD 2
`define PBBMS_EV_REFUSED  3
`define PBBMS_EV_MAIL_BA  4
`define PBBMS_NUM_EV      5

// partial transfer indices: the two that close a long word, then the first index and the step
`define PBBMS_LAST_WORD   2'h1
`define PBBMS_LAST_BYTE   2'h3
`define PBBMS_IDX_FIRST   2'h0
`define PBBMS_IDX_STEP    2'h1

// reset values
`define PBBMS_RST_LW      36'h0_0000_0000
`define PBBMS_RST_REG     32'h0000_0000
`define PBBMS_RST_EV      5'h00

`endif

// >>> logic/pbbms_pkg.sv
// types shared by the port b bus matching and byte swap path
package pbbms_pkg;

  // bus size code as {bus_size_select_1, bus_size_select_0}
  typedef enum logic [1:0] {
    PBBMS_SIZE_LONG = 2'h0,
    PBBMS_SIZE_WORD = 2'h1,
    PBBMS_SIZE_BYTE = 2'h2,
    PBBMS_SIZE_MAIL = 2'h3
  } pbbms_size_t;

  // swap code as {swap_select_high, swap_select_low}
  typedef enum logic [1:0] {
    PBBMS_SWAP_NONE = 2'h0,
    PBBMS_SWAP_FULL = 2'h1,
    PBBMS_SWAP_HALF = 2'h2,
    PBBMS_SWAP_BYTE = 2'h3
  } pbbms_swap_t;

  // port b control pins
  typedef struct packed {
    logic swap_select_high;
    logic swap_select_low;
    logic bus_size_select_1;
    logic bus_size_select_0;
    logic big_endian;
  } pbbms_ctrl_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } pbbms_reg_req_t;

endpackage

// >>> logic/pbbms_swap.sv
// byte order swap of a 36-bit long word; every code is its own inverse
module pbbms_swap (
  input  wire logic [35:0]         din,
  input  wire pbbms_pkg::pbbms_swap_t code,
  output logic      [35:0]         dout
);
  import pbbms_pkg::*;

  logic [8:0] b3, b2, b1, b0;

  // split into byte lanes, top lane first
  assign b3 = din[35:27];
  assign b2 = din[26:18];
  assign b1 = din[17:9];
  assign b0 = din[8:0];

  // lane reorder per code
  always_comb begin
    case (code)
      PBBMS_SWAP_NONE: dout = {b3, b2, b1, b0};
      PBBMS_SWAP_FULL: dout = {b0, b1, b2, b3};
      PBBMS_SWAP_HALF: dout = {b1, b0, b3, b2};
      PBBMS_SWAP_BYTE: dout = {b2, b3, b0, b1};
      default:         dout = {b3, b2, b1, b0};
    endcase
  end
endmodule

// >>> logic/pbbms_irq.sv
// sticky event status with enable mask and level interrupt
`include "pbbms_defines.svh"

module pbbms_irq (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] events,
  input  wire logic       clear_wr,
  input  wire logic       enable_wr,
  input  wire logic [4:0] wdata,
  output logic      [4:0] status,
  output logic      [4:0] enable,
  output logic            irq
);
  // sticky bits; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= `PBBMS_RST_EV;
    end else if (clear_wr) begin
      status <= (status & ~wdata) | events;
    end else begin
      status <= status | events;
    end
  end

  // mask register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= `PBBMS_RST_EV;
    end else if (enable_wr) begin
      enable <= wdata;
    end
  end

  // level output, high while an enabled bit is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~(clear_wr ? wdata : `PBBMS_RST_EV)) | events)
               & (enable_wr ? wdata : enable));
    end
  end
endmodule

// >>> tb/pbbms_tb_pkg.sv
// reference byte swap and lane placement for the bench side
package pbbms_tb_pkg;

  // bytes a,b,c,d from the top lane reordered by swap code
  function automatic logic [35:0] sw(input logic [35:0] d, input logic [1:0] c);
    case (c)
      2'h1: return {d[8:0], d[17:9], d[26:18], d[35:27]};
      2'h2: return {d[17:0], d[35:18]};
      2'h3: return {d[26:18], d[35:27], d[8:0], d[17:9]};
      default: return d;
    endcase
  endfunction

  // lanes used by one part of size z
  function automatic logic [35:0] msk(input logic [1:0] z, input logic be);
    case (z)
      2'h1: return be ? 36'hF_FFFC_0000 : 36'h0_0003_FFFF;
      2'h2: return be ? 36'hF_F800_0000 : 36'h0_0000_01FF;
      default: return 36'hF_FFFF_FFFF;
    endcase
  endfunction

  // part k of swapped word s placed on its lanes; little endian runs backwards
  function automatic logic [35:0] lane(input logic [35:0] s, input logic [1:0] z,
                                       input logic be, input int k);
    int j;
    j = be ? k : ((z == 2'h1) ? 1 - k : 3 - k);
    case (z)
      2'h1: return be ? (s >> (18 * (1 - j))) << 18 : (s >> (18 * (1 - j))) & 36'h0_0003_FFFF;
      2'h2: return be ? (s >> (9 * (3 - j))) << 27 : (s >> (9 * (3 - j))) & 36'h0_0000_01FF;
      default: return s;
    endcase
  endfunction

endpackage

// >>> tb/pbbms_chk.sv
// concurrent checks on the ports of the bus matching path
module pbbms_chk
  import pbbms_pkg::*;
  import pbbms_tb_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst,
  input wire pbbms_reg_req_t reg_req,
  input wire logic [35:0]    a_to_b_data,
  input wire logic           a_to_b_valid,
  input wire logic           a_to_b_ready,
  input wire pbbms_ctrl_t    port_b_ctrl,
  input wire logic           port_b_read,
  input wire logic           port_b_write,
  input wire logic [35:0]    port_b_wdata,
  input wire logic [35:0]    port_b_rdata,
  input wire logic           port_b_empty_flag,
  input wire logic [35:0]    b_to_a_data,
  input wire logic           b_to_a_valid,
  input wire logic           b_to_a_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [35:0] held;
  logic [31:0] mbox;
  logic [1:0]  pc;
  wire  [1:0]  z    = port_b_ctrl[2:1];
  wire         be   = port_b_ctrl[0];
  wire         take = port_b_read && port_b_empty_flag && z != 2'h3;
  wire         last = z == 2'h0 || (z == 2'h1 && pc == 2'h1) || (z == 2'h2 && pc == 2'h3);
  wire  [35:0] hsw  = sw(held, port_b_ctrl[4:3]);

  // loaded word, mailbox and part index seen from the ports
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= '0;
      mbox <= '0;
      pc   <= 2'h0;
    end else begin
      if (a_to_b_valid && a_to_b_ready) held <= a_to_b_data;
      if (reg_req.write && reg_req.addr == 8'h00) mbox <= reg_req.wdata;
      if (take) pc <= last ? 2'h0 : pc + 2'h1;
    end
  end

  sequence load_s;  a_to_b_valid && a_to_b_ready; endsequence
  sequence part_s;  take && !last; endsequence
  sequence close_s; take && last; endsequence

  load_flag_a: assert property (load_s |=> port_b_empty_flag && !a_to_b_ready)
    else $error("flag did not rise after load");
  part_hold_a: assert property (part_s |=> port_b_empty_flag)
    else $error("flag fell before the last part");
  close_drop_a: assert property (close_s |=> !port_b_empty_flag && a_to_b_ready)
    else $error("flag held after the last part");
  long_read_a: assert property (take && z == 2'h0 |=> port_b_rdata == $past(hsw))
    else $error("long read order wrong");
  word_be_a: assert property (take && z == 2'h1 && pc == 2'h0 && be |=>
      port_b_rdata[35:18] == $past(hsw[35:18]) && $stable(port_b_rdata[17:0]))
    else $error("big endian word read wrong");
  word_le_a: assert property (take && z == 2'h1 && pc == 2'h0 && !be |=>
      port_b_rdata[17:0] == $past(hsw[17:0]) && $stable(port_b_rdata[35:18]))
    else $error("little endian word read wrong");
  byte_be_a: assert property (take && z == 2'h2 && pc == 2'h0 && be |=>
      port_b_rdata[35:27] == $past(hsw[35:27]) && $stable(port_b_rdata[26:0]))
    else $error("big endian byte read wrong");
  byte_le_a: assert property (take && z == 2'h2 && !be |=> $stable(port_b_rdata[35:9]))
    else $error("byte read touched unused lanes");
  mail_read_a: assert property (port_b_read && z == 2'h3 |=> port_b_rdata == {4'h0, $past(mbox)})
    else $error("mailbox read wrong");
  long_write_a: assert property (port_b_write && b_to_a_ready && z == 2'h0 |=> b_to_a_valid &&
      b_to_a_data == sw($past(port_b_wdata), $past(port_b_ctrl[4:3])))
    else $error("long write not unswapped");
endmodule

bind pbbms_top pbbms_chk pbbms_chk_inst (.clk(clk), .rst(rst), .reg_req(reg_req),
  .a_to_b_data(a_to_b_data), .a_to_b_valid(a_to_b_valid), .a_to_b_ready(a_to_b_ready),
  .port_b_ctrl(port_b_ctrl), .port_b_read(port_b_read), .port_b_write(port_b_write),
  .port_b_wdata(port_b_wdata), .port_b_rdata(port_b_rdata),
  .port_b_empty_flag(port_b_empty_flag), .b_to_a_data(b_to_a_data),
  .b_to_a_valid(b_to_a_valid), .b_to_a_ready(b_to_a_ready));

// >>> tb/pbbms_port_b_ctl.sv
// port b controller model: one read or write part per call
module pbbms_port_b_ctl
  import pbbms_pkg::*;
  import pbbms_tb_pkg::*;
(
  input  wire logic   clk,
  output pbbms_ctrl_t ctrl,
  output logic        rd,
  output logic        wr,
  output logic [35:0] wd
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle at time zero
  initial begin
    ctrl = '0;
    rd = 1'b0;
    wr = 1'b0;
    wd = '0;
  end

  // one read part; the caller keeps the selects fixed for a long word
  task automatic rd_part(input pbbms_ctrl_t c);
    @(posedge clk);
    ctrl <= c;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask

  // one write part; unused and released lanes show inverted old data
  task automatic wr_part(input pbbms_ctrl_t c, input logic [35:0] s, input int k);
    @(posedge clk);
    ctrl <= c;
    wr <= 1'b1;
    wd <= lane(s, c[2:1], c[0], k) | (~msk(c[2:1], c[0]) & ~wd);
    @(posedge clk);
    wr <= 1'b0;
    wd <= ~wd;
    #1;
  endtask
endmodule

// >>> tb/pbbms_bench.sv
// self-checking bench for the port b bus matching and byte swap path
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end

module pbbms_bench;
  import pbbms_pkg::*;
  import pbbms_tb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {pbbms_ctrl_t c; logic [35:0] d; logic [35:0] x;} pbbms_row_t;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  pbbms_reg_req_t req = '0;
  logic [35:0]    ad  = '0;
  logic           av  = 1'b0;
  logic           br  = 1'b1;
  logic [31:0]    rdat, v;
  logic [35:0]    rdo, bd, wd, er;
  logic           irq, ardy, flag, bv, rd, wr;
  pbbms_ctrl_t    ctrl;
  pbbms_row_t     rows[24];
  int             failures = 0;
  int             tests_run = 0;

  always #5 clk = ~clk;

  pbbms_top pbbms_top_inst (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdat), .irq(irq),
    .a_to_b_data(ad), .a_to_b_valid(av), .a_to_b_ready(ardy), .port_b_ctrl(ctrl),
    .port_b_read(rd), .port_b_write(wr), .port_b_wdata(wd), .port_b_rdata(rdo),
    .port_b_empty_flag(flag), .b_to_a_data(bd), .b_to_a_valid(bv), .b_to_a_ready(br));
  pbbms_port_b_ctl pbbms_port_b_ctl_inst (.clk(clk), .ctrl(ctrl), .rd(rd), .wr(wr), .wd(wd));

  function automatic int np(input logic [1:0] z);
    return (z == 2'h0) ? 1 : ((z == 2'h1) ? 2 : 4);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // offers one long word from the a-to-b side
  task automatic ld(input logic [35:0] d);
    @(posedge clk);
    av <= 1'b1;
    ad <= d;
    @(posedge clk);
    av <= 1'b0;
    ad <= ~d;
    #1;
    `CHK({flag, ardy}, 2'h2)
  endtask

  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '{a, ~d, 1'b0, 1'b0};
    #1;
  endtask

  task automatic rr(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    req.read <= 1'b0;
    #1;
    q = rdat;
  endtask

  // reads a long word part by part, tracking the output register
  task automatic rd_lw(input pbbms_ctrl_t c, input logic [35:0] x);
    for (int k = 0; k < np(c[2:1]); k++) begin
      pbbms_port_b_ctl_inst.rd_part(c);
      er = (er & ~msk(c[2:1], c[0])) | lane(x, c[2:1], c[0], k);
      `CHK(rdo, er)
      `CHK(flag, k != np(c[2:1]) - 1)
    end
  endtask

  // writes a swapped long word part by part
  task automatic wr_lw(input pbbms_ctrl_t c, input logic [35:0] d, input logic [35:0] x);
    for (int k = 0; k < np(c[2:1]); k++) begin
      pbbms_port_b_ctl_inst.wr_part(c, x, k);
      `CHK(bv, k == np(c[2:1]) - 1)
    end
    `CHK(bd, d)
  endtask

  task automatic test_done;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // every swap code, size and lane order
  initial begin
    int n;
    n = 0;
    er = '0;
    for (int s = 0; s < 4; s++) for (int z = 0; z < 3; z++) for (int b = 0; b < 2; b++) begin
      rows[n].c = {s[1:0], z[1:0], b[0]};
      rows[n].d = 36'h9_8765_4321 ^ 36'(n * 7);
      rows[n].x = sw(rows[n].d, s[1:0]);
      n++;
    end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    `CHK({ardy, flag, bv, irq, rdo}, {4'h8, 36'h0_0000_0000})
    foreach (rows[i]) begin
      ld(rows[i].d);
      rd_lw(rows[i].c, rows[i].x);
      wr_lw(rows[i].c, rows[i].d, rows[i].x);
    end
    // mailbox read between the two halves of a word
    rw(8'h00, 32'hA5C3_0F96);
    ld(36'h1_2345_6789);
    pbbms_port_b_ctl_inst.rd_part(5'h13);
    pbbms_port_b_ctl_inst.rd_part(5'h1F);
    `CHK(rdo, 36'h0_A5C3_0F96)
    `CHK(flag, 1'b1)
    pbbms_port_b_ctl_inst.rd_part(5'h13);
    `CHK(rdo[35:18], 18'(sw(36'h1_2345_6789, 2'h2)))
    `CHK(flag, 1'b0)
    // interrupt raised, masked and cleared
    rw(8'h0C, 32'h0000_001F);
    rw(8'h10, 32'h0000_0001);
    ld(36'h0_0000_0003);
    tick(2);
    `CHK(irq, 1'b1)
    rw(8'h10, 32'h0000_0000);
    tick(2);
    `CHK(irq, 1'b0)
    rw(8'h10, 32'h0000_0001);
    rw(8'h0C, 32'h0000_0001);
    tick(2);
    `CHK(irq, 1'b0)
    rd_lw(5'h00, 36'h0_0000_0003);
    // refused read on empty, dropped write, unmapped read, port b mail write
    rw(8'h0C, 32'h0000_001F);
    pbbms_port_b_ctl_inst.rd_part(5'h00);
    `CHK(rdo, er)
    @(posedge clk) br <= 1'b0;
    pbbms_port_b_ctl_inst.wr_part(5'h00, 36'h0_1234_5678, 0);
    `CHK(bv, 1'b0)
    @(posedge clk) br <= 1'b1;
    pbbms_port_b_ctl_inst.wr_part(5'h06, 36'h0_CAFE_F00D, 0);
    rr(8'h08, v);
    `CHK(v[4:3], 2'h3)
    rr(8'h04, v);
    `CHK(v, 32'hCAFE_F00D)
    rr(8'h40, v);
    `CHK(v, 32'h0000_0000)
    // second reset with a word held, then recovery
    ld(36'h0_0F0F_0F0F);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    tick(1);
    `CHK({ardy, flag}, 2'h2)
    er = '0;
    ld(rows[11].d);
    rd_lw(rows[11].c, rows[11].x);
    test_done;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule
